// ### inc/mts_pkg.sv
// Purpose: Shared constants and carrier types of the temperature conversion sequencer.
// Assumes: One 200 MHz clock; channel index 0..6 maps to remote 1..3, local, thermistor 1..3.
// Notes: Timing counts are derived from the times here, not typed as cycle figures.
// Notes on behaviour
// - Default order: remote 1, 2, 3, local, thermistor 1, 2, 3, then repeat.
// - Each finished conversion is stored in that channel's own result register.
// - Configuration bit 4 set by host selects the fast channel-1 sequence.
// - Fast mode puts remote channel 1 between every other channel.
// - Thermistor reference is on only while a thermistor channel converts.
// - Every channel has an alert limit; channels 1, 4, 5, 6 an overtemperature limit.
// - Overtemperature output goes low when channel 1, 4, 5 or 6 exceeds its limit.
// - Alert output goes low when a monitored channel exceeds its alert limit.
// - Thermistor results are a fraction of the reference voltage, not degrees.
// - Host sets the standby bit; the converter then stops.
// - Standby keeps all stored results and the serial interface keeps working.
// - In standby the bus timeout is armed only after a start condition.
// - Standby during a conversion abandons it; earlier results stay readable.
// - Serial interface resets when its clock stays low beyond 25 to 45 ms.
package mts_pkg;
  localparam int CH_N = 7;
  localparam int CH_W = 3;
  localparam int DATA_W = 8;
  localparam int CFG_W = 8;
  localparam int CFG_FAST_BIT = 4;
  localparam int CFG_STANDBY_BIT = 6;
  localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
  localparam logic [CH_W-1:0] CH_LAST = 3'h6;
  localparam logic [CH_W-1:0] CH_OTHER_FIRST = 3'h1;
  localparam logic [CH_W-1:0] CH_THERM_FIRST = 3'h4;
  localparam logic [CH_N-1:0] OVERTEMP_OUT_N_CH_MASK = 7'h39;
  localparam logic [CH_N-1:0] ALERT_CH_MASK = 7'h7f;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic start;
    logic [CH_W-1:0] ch;
  } mts_conv_req_s;

  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] data;
  } mts_conv_rsp_s;
endpackage : mts_pkg

// ### hw/mts_sync2.sv
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous levels.
// Notes: Only the second stage may be read by logic.
`timescale 1ns/1ps
module mts_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '1;
      q_o <= '1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : mts_sync2

// ### hw/mts_cmp.sv
// Purpose: One threshold flag, refreshed when its channel's result is stored.
// Assumes: upd_i is a one-cycle pulse in the cycle the new value is stored.
// Notes: A disabled comparator holds its flag low.
`timescale 1ns/1ps
module mts_cmp #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic upd_i,
  input wire logic [W-1:0] val_i,
  input wire logic [W-1:0] lim_i,
  output logic flag_o
);
  wire over = val_i > lim_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (upd_i) begin
      flag_o <= en_i & over;
    end
  end
endmodule : mts_cmp

// ### hw/mts_seq_top.sv
// Purpose: Channel sequencer, result store, threshold alarms and bus timeout.
// Assumes: The converter and serial pins sit outside; converter answers on this clock.
// Notes: Alarm pins are open drain; the pin is pulled low while its enable is high.
`timescale 1ns/1ps
module mts_seq_top #(
  parameter int TIMEOUT_CYCLES = mts_pkg::TIMEOUT_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [mts_pkg::CFG_W-1:0] CFG1_I,
  input wire logic [mts_pkg::CH_N-1:0][mts_pkg::DATA_W-1:0] ALERT_LIM_I,
  input wire logic [mts_pkg::CH_N-1:0][mts_pkg::DATA_W-1:0] OVERTEMP_OUT_N_LIM_I,
  output mts_pkg::mts_conv_req_s CONV_REQ_O,
  input wire mts_pkg::mts_conv_rsp_s CONV_RSP_I,
  output logic THERM_REF_EN_O,
  output logic [mts_pkg::CH_N-1:0][mts_pkg::DATA_W-1:0] TEMP_DATA_O,
  output logic [mts_pkg::CH_N-1:0] ALERT_STAT_O,
  output logic [mts_pkg::CH_N-1:0] OVERTEMP_OUT_N_STAT_O,
  output logic STANDBY_O,
  input wire logic SERIAL_BUS_CLOCK_PIN_I,
  input wire logic SERIAL_BUS_DATA_PIN_I,
  output logic BUS_RESET_O,
  output logic ALERT_N_O,
  output logic ALERT_OE_O,
  output logic OVERTEMP_OUT_N_O,
  output logic OVERTEMP_OE_O
);
  import mts_pkg::*;

  typedef enum logic [1:0] {ST_HALT, ST_ISSUE, ST_WAIT} mts_state_e;

  mts_state_e state;
  mts_state_e next_state;
  logic [CH_W-1:0] ch;
  logic [CH_W-1:0] other;
  logic [CH_W-1:0] next_ch;
  logic [CH_W-1:0] next_other;
  logic vref;
  logic [CH_N-1:0][DATA_W-1:0] result;

  // Host configuration bits, read straight from the first configuration register.
  wire fast_mode = CFG1_I[CFG_FAST_BIT];
  wire standby = CFG1_I[CFG_STANDBY_BIT];

  // Standby wins over a finishing conversion, so the result is dropped.
  wire store = (state == ST_WAIT) && CONV_RSP_I.done && !standby;
  wire is_therm = ch >= CH_THERM_FIRST;

  // Sequence stepping for both orders.
  wire [CH_W-1:0] ch_plus = (ch == CH_LAST) ? CH_FIRST : ch + 3'h1;
  wire [CH_W-1:0] other_plus = (other == CH_LAST) ? CH_OTHER_FIRST : other + 3'h1;
  wire [CH_W-1:0] fast_next = (ch == CH_FIRST) ? other : CH_FIRST;
  wire [CH_W-1:0] step_ch = fast_mode ? fast_next : ch_plus;
  wire leaving_other = fast_mode && (ch != CH_FIRST);

  always_comb begin
    next_state = state;
    next_ch = ch;
    next_other = other;
    case (state)
      ST_HALT: begin
        next_ch = CH_FIRST;
        next_other = CH_OTHER_FIRST;
        if (!standby) begin
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        next_state = standby ? ST_HALT : ST_WAIT;
      end
      ST_WAIT: begin
        if (standby) begin
          next_state = ST_HALT;
        end else if (CONV_RSP_I.done) begin
          next_state = ST_ISSUE;
          next_ch = step_ch;
          if (leaving_other) begin
            next_other = other_plus;
          end
        end
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= ST_ISSUE;
      ch <= CH_FIRST;
      other <= CH_OTHER_FIRST;
      vref <= 1'b0;
    end else begin
      state <= next_state;
      ch <= next_ch;
      other <= next_other;
      vref <= (next_state != ST_HALT) && (next_ch >= CH_THERM_FIRST);
    end
  end

  // Results survive standby untouched; only a completed conversion writes.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      result <= {CH_N{RESULT_RST}};
    end else if (store) begin
      // Thermistor codes are kept as the reference fraction the converter gives.
      result[ch] <= CONV_RSP_I.data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_lim
      mts_cmp #(.W(DATA_W)) u_alert (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .en_i(ALERT_CH_MASK[g]),
        .upd_i(store && (ch == CH_W'(g))),
        .val_i(CONV_RSP_I.data),
        .lim_i(ALERT_LIM_I[g]),
        .flag_o(ALERT_STAT_O[g])
      );
      mts_cmp #(.W(DATA_W)) u_overtemp_out_n (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .en_i(OVERTEMP_OUT_N_CH_MASK[g]),
        .upd_i(store && (ch == CH_W'(g))),
        .val_i(CONV_RSP_I.data),
        .lim_i(OVERTEMP_OUT_N_LIM_I[g]),
        .flag_o(OVERTEMP_OUT_N_STAT_O[g])
      );
    end
  endgenerate

  assign CONV_REQ_O.start = (state == ST_ISSUE) && !standby;
  assign CONV_REQ_O.ch = ch;
  assign THERM_REF_EN_O = vref;
  assign TEMP_DATA_O = result;
  assign STANDBY_O = (state == ST_HALT);
  assign ALERT_OE_O = |ALERT_STAT_O;
  assign ALERT_N_O = 1'b0;
  assign OVERTEMP_OE_O = |OVERTEMP_OUT_N_STAT_O;
  assign OVERTEMP_OUT_N_O = 1'b0;

  // Serial pins are watched only for start, stop and a stuck-low clock.
  logic [1:0] pin_sync;
  logic scl_d;
  logic sda_d;
  logic armed;
  logic [31:0] low_cnt;
  logic bus_rst;

  mts_sync2 #(.W(2)) u_pin_sync (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i({SERIAL_BUS_CLOCK_PIN_I, SERIAL_BUS_DATA_PIN_I}),
    .q_o(pin_sync)
  );

  wire scl = pin_sync[1];
  wire sda = pin_sync[0];
  wire start_cond = scl && scl_d && sda_d && !sda;
  wire stop_cond = scl && scl_d && !sda_d && sda;
  wire tmo_live = !standby || armed;
  wire tmo_hit = low_cnt >= 32'(TIMEOUT_CYCLES);

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      armed <= 1'b0;
      low_cnt <= 32'h0;
      bus_rst <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      // A new start keeps the timeout armed even if a timeout fires together.
      if (start_cond) begin
        armed <= 1'b1;
      end else if (stop_cond || bus_rst) begin
        armed <= 1'b0;
      end
      // The count is cleared only on the edge after the pulse rises, so the pulse
      // must block itself or it would last two cycles.
      bus_rst <= tmo_live && !scl && tmo_hit && !bus_rst;
      if (scl || !tmo_live || bus_rst) begin
        low_cnt <= 32'h0;
      end else if (!tmo_hit) begin
        low_cnt <= low_cnt + 32'h1;
      end
    end
  end

  assign BUS_RESET_O = bus_rst;

  // Checks of the sequencing, reference, standby, alarm and bus timeout behaviour.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic [CH_W-1:0] last_ch;
  logic [DATA_W-1:0] last_data;
  logic last_store;
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_ch <= CH_FIRST;
      last_data <= RESULT_RST;
      last_store <= 1'b0;
    end else begin
      last_ch <= ch;
      last_data <= CONV_RSP_I.data;
      last_store <= store;
    end
  end

  a_store_result: assert property (last_store |-> TEMP_DATA_O[last_ch] == last_data)
    else $error("Stored result does not match converter data.");
  a_default_order: assert property (store && !fast_mode |=> ch == $past(ch_plus))
    else $error("Default sequence stepped to the wrong channel.");
  a_fast_revisit: assert property (store && fast_mode && ch != CH_FIRST |=> ch == CH_FIRST)
    else $error("Fast mode did not return to channel one.");
  a_fast_other: assert property (store && fast_mode && ch == CH_FIRST |=> ch != CH_FIRST)
    else $error("Fast mode repeated channel one.");
  a_vref_diode: assert property (state == ST_WAIT && !is_therm |-> !THERM_REF_EN_O)
    else $error("Reference on during a diode conversion.");
  a_vref_therm: assert property (state == ST_WAIT && is_therm |-> THERM_REF_EN_O)
    else $error("Reference off during a thermistor conversion.");
  a_standby_halt: assert property (standby |=> STANDBY_O ##0 !CONV_REQ_O.start)
    else $error("Converter kept running in standby.");
  a_abort_keep: assert property (standby && state == ST_WAIT |=> $stable(TEMP_DATA_O)[*2])
    else $error("Results changed after an abandoned conversion.");
  a_resume_first: assert property (STANDBY_O && !standby |=> CONV_REQ_O.start && ch == CH_FIRST)
    else $error("Sequence did not resume from the first channel.");
  a_alert_level: assert property (last_store && last_data > ALERT_LIM_I[last_ch] |-> ALERT_OE_O)
    else $error("Alert not driven after a limit was exceeded.");
  a_overtemp_out_n_chan: assert property (last_store && OVERTEMP_OUT_N_CH_MASK[last_ch]
      && last_data > OVERTEMP_OUT_N_LIM_I[last_ch] |-> OVERTEMP_OE_O)
    else $error("Overtemperature not driven after a limit was exceeded.");
  a_strict_cmp: assert property (last_store |-> ALERT_STAT_O[last_ch]
      == (last_data > ALERT_LIM_I[last_ch]))
    else $error("Alert flag disagrees with a strict comparison.");
  a_tmo_armed: assert property (standby && !armed |-> !BUS_RESET_O ##1 !BUS_RESET_O)
    else $error("Bus timeout fired while not armed in standby.");
  a_tmo_pulse: assert property (BUS_RESET_O |=> !BUS_RESET_O)
    else $error("Bus reset lasted more than one cycle.");

  c_fast_wrap: cover property (store && fast_mode && ch == CH_LAST);
  c_default_wrap: cover property (store && !fast_mode && ch == CH_LAST);
  c_abort: cover property (standby && state == ST_WAIT && CONV_RSP_I.done);
  c_bus_reset: cover property (BUS_RESET_O);
endmodule : mts_seq_top

// ### testbench/mts_conv_model.sv
// Purpose: Behavioural converter that answers each conversion request of the sequencer.
// Assumes: One request is outstanding at a time; the answer delay is set by lat_i.
// Notes: Between answers the data lines toggle so that a stale value is never read as good.
`timescale 1ns/1ps
module mts_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mts_pkg::mts_conv_req_s req_i,
  input wire logic [7:0] base_i,
  input wire logic [7:0] lat_i,
  output mts_pkg::mts_conv_rsp_s rsp_o
);
  import mts_pkg::*;
  logic busy;
  logic [7:0] cnt;
  logic [CH_W-1:0] ch;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      ch <= '0;
      rsp_o <= '0;
    end else begin
      rsp_o.done <= 1'b0;
      rsp_o.data <= ~rsp_o.data;
      if (req_i.start && !busy) begin
        busy <= 1'b1;
        cnt <= lat_i;
        ch <= req_i.ch;
      end else if (busy && cnt <= 8'h01) begin
        busy <= 1'b0;
        rsp_o.done <= 1'b1;
        rsp_o.data <= base_i + 8'(ch);
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : mts_conv_model

// ### testbench/tb.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: The converter model answers with base plus channel index.
// Notes: A short bus timeout keeps the run brief.
`timescale 1ns/1ps
module tb;
  import mts_pkg::*;
  localparam int TO = 50;
  logic clk = 0, rst = 1, scl = 1, sda = 1, prv_ok = 0;
  logic [CFG_W-1:0] cfg = '0;
  logic [CH_N-1:0][DATA_W-1:0] alim, olim, temp;
  logic [7:0] base = 8'h40, lat = 8'h03;
  logic [CH_W-1:0] prv, c;
  mts_conv_req_s req;
  mts_conv_rsp_s rsp;
  logic tref, sby, brst, an, aoe, on, ooe;
  logic [CH_N-1:0] ast, ost;
  int bad_count = 0, samples_checked = 0, cyc = 0, p, q;
  initial forever #2.5 clk = ~clk;
  mts_seq_top #(.TIMEOUT_CYCLES(TO)) DUT (.REF_CLK_I(clk), .SYS_RST_I(rst), .CFG1_I(cfg),
    .ALERT_LIM_I(alim), .OVERTEMP_OUT_N_LIM_I(olim), .CONV_REQ_O(req), .CONV_RSP_I(rsp),
    .THERM_REF_EN_O(tref), .TEMP_DATA_O(temp), .ALERT_STAT_O(ast), .OVERTEMP_OUT_N_STAT_O(ost),
    .STANDBY_O(sby), .SERIAL_BUS_CLOCK_PIN_I(scl), .SERIAL_BUS_DATA_PIN_I(sda),
    .BUS_RESET_O(brst), .ALERT_N_O(an), .ALERT_OE_O(aoe), .OVERTEMP_OUT_N_O(on),
    .OVERTEMP_OE_O(ooe));
  mts_conv_model CONV (.clk_i(clk), .rst_i(rst), .req_i(req), .base_i(base), .lat_i(lat),
    .rsp_o(rsp));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task next_start(output logic [CH_W-1:0] ch);
    int n;
    n = 0;
    @(negedge clk);
    while (req.start !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n < 400, 1);
    ch = req.ch;
    chk(tref, ch >= 3'h4);
    if (prv_ok) chk(temp[prv], base + 8'(prv));
    prv = ch;
    prv_ok = 1;
  endtask : next_start
  task seq(input logic fast, input int n);
    for (int i = 0; i < n; i++) begin
      next_start(c);
      chk(c, fast ? ((i % 2) ? 3'((i / 2) % 6 + 1) : 3'h0) : 3'(i % 7));
    end
  endtask : seq
  // Counts bus reset pulses in p and conversion requests in q.
  task watch(input int n);
    p = 0;
    q = 0;
    repeat (n) begin
      @(negedge clk);
      if (brst === 1'b1) p++;
      if (req.start === 1'b1) q++;
    end
  endtask : watch
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    // Odd channels sit one below their result, even ones equal it: only odd ones may alarm.
    for (int i = 0; i < CH_N; i++) begin
      alim[i] = i[0] ? 8'h3f + 8'(i) : 8'h40 + 8'(i);
      olim[i] = 8'h00;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    seq(0, 14);
    chk(ast, 7'h2a);
    chk(ost, 7'h39);
    chk({an, on, aoe, ooe}, 4'h3);
    @(posedge clk);
    alim <= '1;
    olim <= '1;
    seq(0, 8);
    chk({ast, ost, aoe, ooe}, 16'h0);
    $display("test default order and alarms done");
    @(posedge clk);
    cfg <= 8'h50;
    repeat (20) @(posedge clk);
    cfg <= 8'h10;
    prv_ok = 0;
    seq(1, 14);
    $display("test fast order done");
    @(posedge clk);
    cfg <= 8'h40;
    lat <= 8'h28;
    repeat (20) @(posedge clk);
    cfg <= 8'h00;
    prv_ok = 0;
    next_start(c);
    chk(c, 3'h0);
    @(posedge clk);
    base <= 8'h80;
    repeat (5) @(posedge clk);
    cfg <= 8'h40;
    repeat (2) @(negedge clk);
    chk(sby, 1);
    @(posedge clk);
    scl <= 1'b0;
    watch(100);
    chk(q, 0);
    chk(p, 0);
    for (int i = 0; i < CH_N; i++) chk(temp[i], 8'h40 + 8'(i));
    @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda <= 1'b0;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
    watch(80);
    chk(p > 0, 1);
    @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda <= 1'b1;
    $display("test standby done");
    @(posedge clk);
    cfg <= 8'h00;
    lat <= 8'h02;
    prv_ok = 0;
    seq(0, 8);
    @(posedge clk);
    scl <= 1'b0;
    watch(75);
    chk(p, 1);
    @(posedge clk);
    scl <= 1'b1;
    $display("test bus timeout done");
    wrap_up();
  end
endmodule : tb
